// File: verilog/pll_ref_and_feedback_dividers.sv
// Summary of operation
// - Reference divider is 14 bits and divides by 1 to 16383.
// - Reference divide value zero behaves as divide by one.
// - Reference value: upper six bits and lower eight bits from two fields.
// - Reference divider output drives one detector input.
// - Feedback divider: 3-bit prescaler mode, 6-bit swallow, 13-bit main counter.
// - Fixed modes: 000 divides by 1, 001 by 2, 111 by 3.
// - Codes 010 to 110 give dual-modulus 2/3, 4/5, 8/9, 16/17, 32/33.
// - Fixed mode ignores swallow counter; main counter may need bypass.
// - Main bypass bit set makes main counter divide by one.
// - Main count reads zero after reset until software overwrites it.
// - One shared reset bit clears reference, swallow and main counters.
// - Swallow and main counters have their own dedicated reset bit.
// - Dual-modulus total division equals ratio times main plus swallow.
// - Fixed-divide total division equals ratio times main count.
// - Mode combinations reach every integer total division down to one.
// - Only the oscillator input feeds the feedback divider.
// - Select cleared routes oscillator to distribution; default routes other input.
// - Detector compares reference and feedback outputs for phase and frequency.
module pll_ref_and_feedback_dividers
	import pll_div_pkg::*;
(
	input  wire logic                    sys_clk_i,                  // 200 MHz clock
	input  wire logic                    sys_rst_i,                  // Sync reset, high
	input  wire logic                    reference_clock_input_i,    // Reference pin
	input  wire logic                    oscillator_clock_input_i,   // Oscillator pin
	input  wire logic                    distribution_clock_input_i, // Distribution pin
	input  wire logic [REF_DIV_HI_W-1:0] ref_div_hi_i,               // Ref value upper
	input  wire logic [REF_DIV_LO_W-1:0] ref_div_lo_i,               // Ref value lower
	input  wire logic [PRESC_MODE_W-1:0] prescaler_mode_i,           // Prescaler mode
	input  wire logic [SWALLOW_W-1:0]    swallow_count_i,            // Swallow count
	input  wire logic [MAIN_W-1:0]       main_count_i,               // Main count
	input  wire logic                    main_count_we_i,            // Main count load
	input  wire logic                    main_bypass_i,              // Main bypass
	input  wire logic                    shared_counter_reset_i,     // All counters
	input  wire logic                    feedback_counter_reset_i,   // Swallow and main
	input  wire logic                    dist_source_sel_i,          // 0 = oscillator
	output logic                         pfd_ref_pulse_o,            // Ref divider out
	output logic                         pfd_fb_pulse_o,             // Fb divider out
	output logic                         pfd_up_o,                   // Detector up
	output logic                         pfd_down_o,                 // Detector down
	output logic [MAIN_W-1:0]            main_count_o,               // Main readback
	output logic                         dist_clock_o                // Distribution out
);

	typedef enum { FB_LOAD, FB_RUN } fb_state_t;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [PIN_COUNT-1:0]    meta_reg;
	logic [PIN_COUNT-1:0]    sync_reg;
	logic [PIN_COUNT-1:0]    prev_reg;
	logic                    ref_edge;
	logic                    osc_edge;

	logic [REF_DIV_HI_W-1:0] ref_div_hi_reg;
	logic [REF_DIV_LO_W-1:0] ref_div_lo_reg;
	logic [PRESC_MODE_W-1:0] presc_mode_reg;
	logic [SWALLOW_W-1:0]    swallow_reg;
	logic [MAIN_W-1:0]       main_reg;
	logic                    bypass_reg;
	logic                    dist_sel_reg;

	logic [5:0]              base_ratio;
	logic                    dual_mode;
	logic [PRESC_CNT_W-1:0]  presc_last;
	logic [PRESC_CNT_W-1:0]  presc_cnt_reg;
	logic                    presc_tick;
	logic [SWALLOW_W-1:0]    swallow_left_reg;
	logic [MAIN_W-1:0]       main_left_reg;
	logic                    main_expire;
	logic                    fb_clear;
	fb_state_t               fb_state_reg;
	logic                    fb_pulse_reg;

	div_link_if              ref_link ();

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// Two flops per pin; a third flop gives the edge detector history
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
			prev_reg <= '0;
		end
		else
		begin
			meta_reg <= {distribution_clock_input_i, oscillator_clock_input_i,
				reference_clock_input_i};
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// Rising edges become one-cycle enables; limits input rate below 100 MHz
	assign ref_edge = sync_reg[PIN_REF] && !prev_reg[PIN_REF];
	assign osc_edge = sync_reg[PIN_OSC] && !prev_reg[PIN_OSC];

	// ------------------------------------------------------------
	// Configuration copies
	// ------------------------------------------------------------
	// Ports are sampled every cycle so a change acts on the next edge
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			ref_div_hi_reg <= RST_REF_DIV_HI;
			ref_div_lo_reg <= RST_REF_DIV_LO;
			presc_mode_reg <= RST_PRESC_MODE;
			swallow_reg    <= RST_SWALLOW;
			bypass_reg     <= RST_MAIN_BYPASS;
			dist_sel_reg   <= RST_DIST_SEL;
		end
		else
		begin
			ref_div_hi_reg <= ref_div_hi_i;
			ref_div_lo_reg <= ref_div_lo_i;
			presc_mode_reg <= prescaler_mode_i;
			swallow_reg    <= swallow_count_i;
			bypass_reg     <= main_bypass_i;
			dist_sel_reg   <= dist_source_sel_i;
		end
	end

	// Main count holds zero from reset until software loads it
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			main_reg <= RST_MAIN;
		else if (main_count_we_i)
			main_reg <= main_count_i;
	end

	// ------------------------------------------------------------
	// Reference divider
	// ------------------------------------------------------------
	// Shared reset restarts the reference divider as well
	assign ref_link.en      = ref_edge;
	assign ref_link.clear   = shared_counter_reset_i;
	assign ref_link.divisor = {ref_div_hi_reg, ref_div_lo_reg};

	edge_divider u_ref_div (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.link      (ref_link.div)
	);

	// ------------------------------------------------------------
	// Prescaler mode decode
	// ------------------------------------------------------------
	always_comb
	begin
		base_ratio = RATIO_1;
		dual_mode  = 1'b0;
		case (presc_mode_reg)
			MODE_FD_DIV1:  base_ratio = RATIO_1;
			MODE_FD_DIV2:  base_ratio = RATIO_2;
			MODE_FD_DIV3:  base_ratio = RATIO_3;
			MODE_DM_2_3:
			begin
				base_ratio = RATIO_2;
				dual_mode  = 1'b1;
			end
			MODE_DM_4_5:
			begin
				base_ratio = RATIO_4;
				dual_mode  = 1'b1;
			end
			MODE_DM_8_9:
			begin
				base_ratio = RATIO_8;
				dual_mode  = 1'b1;
			end
			MODE_DM_16_17:
			begin
				base_ratio = RATIO_16;
				dual_mode  = 1'b1;
			end
			MODE_DM_32_33:
			begin
				base_ratio = RATIO_32;
				dual_mode  = 1'b1;
			end
			default:
			begin
				base_ratio = RATIO_1;
				dual_mode  = 1'b0;
			end
		endcase
	end

	// Ratio plus one while swallow cycles remain, ratio afterwards
	always_comb
	begin
		if (dual_mode && swallow_left_reg != '0)
			presc_last = base_ratio;
		else
			presc_last = base_ratio - 6'h01;
	end

	assign presc_tick = osc_edge && (presc_cnt_reg >= presc_last);

	// ------------------------------------------------------------
	// Feedback counters
	// ------------------------------------------------------------
	// Either reset bit clears swallow and main; used mainly for test
	assign fb_clear = shared_counter_reset_i || feedback_counter_reset_i;

	// Bypass or a count of one or zero expires on every prescaler cycle
	assign main_expire = bypass_reg || (main_left_reg <= MAIN_W'(1));

	// Prescaler cycle counter on oscillator edges only
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i || fb_clear || fb_state_reg == FB_LOAD)
			presc_cnt_reg <= '0;
		else if (osc_edge)
		begin
			if (presc_cnt_reg >= presc_last)
				presc_cnt_reg <= '0;
			else
				presc_cnt_reg <= presc_cnt_reg + PRESC_CNT_W'(1);
		end
	end

	// Load after any reset, then run and reload at main expiry
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i || fb_clear)
			fb_state_reg <= FB_LOAD;
		else
		begin
			case (fb_state_reg)
				FB_LOAD: fb_state_reg <= FB_RUN;
				FB_RUN:  fb_state_reg <= FB_RUN;
				default: fb_state_reg <= FB_LOAD;
			endcase
		end
	end

	// Swallow and main down-counters; total = ratio*main + swallow
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i || fb_clear)
		begin
			swallow_left_reg <= '0;
			main_left_reg    <= '0;
		end
		else if (fb_state_reg == FB_LOAD || (presc_tick && main_expire))
		begin
			swallow_left_reg <= dual_mode ? swallow_reg : '0;
			main_left_reg    <= main_reg;
		end
		else if (presc_tick)
		begin
			main_left_reg <= main_left_reg - MAIN_W'(1);
			if (swallow_left_reg != '0)
				swallow_left_reg <= swallow_left_reg - SWALLOW_W'(1);
		end
	end

	// Output pulse per full feedback period; ratio one with bypass gives one
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i || fb_clear)
			fb_pulse_reg <= 1'b0;
		else
			fb_pulse_reg <= fb_state_reg == FB_RUN && presc_tick && main_expire;
	end

	// ------------------------------------------------------------
	// Detector inputs
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			pfd_ref_pulse_o <= 1'b0;
			pfd_fb_pulse_o  <= 1'b0;
		end
		else
		begin
			pfd_ref_pulse_o <= ref_link.pulse;
			pfd_fb_pulse_o  <= fb_pulse_reg;
		end
	end

	// ------------------------------------------------------------
	// Phase/frequency detector
	// ------------------------------------------------------------
	// Tri-state style: each side latches, both high resets both
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			pfd_up_o   <= 1'b0;
			pfd_down_o <= 1'b0;
		end
		else if ((pfd_up_o || pfd_ref_pulse_o) && (pfd_down_o || pfd_fb_pulse_o))
		begin
			pfd_up_o   <= 1'b0;
			pfd_down_o <= 1'b0;
		end
		else
		begin
			pfd_up_o   <= pfd_up_o || pfd_ref_pulse_o;
			pfd_down_o <= pfd_down_o || pfd_fb_pulse_o;
		end
	end

	// ------------------------------------------------------------
	// Distribution source and readback
	// ------------------------------------------------------------
	// Sampled copy only; real jitter-free muxing belongs in the pad ring
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			dist_clock_o <= 1'b0;
			main_count_o <= RST_MAIN;
		end
		else
		begin
			dist_clock_o <= dist_sel_reg ? sync_reg[PIN_DIST] : sync_reg[PIN_OSC];
			main_count_o <= main_reg;
		end
	end

endmodule

// File: verilog/pll_div_pkg.sv
package pll_div_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int REF_DIV_W       = 14;
	localparam int REF_DIV_HI_W    = 6;
	localparam int REF_DIV_LO_W    = 8;
	localparam int PRESC_MODE_W    = 3;
	localparam int SWALLOW_W       = 6;
	localparam int MAIN_W          = 13;
	localparam int PRESC_CNT_W     = 6;
	localparam int PIN_COUNT       = 3;

	// ------------------------------------------------------------
	// Pin index in the synchroniser bank
	// ------------------------------------------------------------
	localparam int PIN_REF         = 0;
	localparam int PIN_OSC         = 1;
	localparam int PIN_DIST        = 2;

	// ------------------------------------------------------------
	// Prescaler mode codes
	// ------------------------------------------------------------
	localparam logic [2:0] MODE_FD_DIV1  = 3'h0;
	localparam logic [2:0] MODE_FD_DIV2  = 3'h1;
	localparam logic [2:0] MODE_DM_2_3   = 3'h2;
	localparam logic [2:0] MODE_DM_4_5   = 3'h3;
	localparam logic [2:0] MODE_DM_8_9   = 3'h4;
	localparam logic [2:0] MODE_DM_16_17 = 3'h5;
	localparam logic [2:0] MODE_DM_32_33 = 3'h6;
	localparam logic [2:0] MODE_FD_DIV3  = 3'h7;

	// ------------------------------------------------------------
	// Prescaler base ratios
	// ------------------------------------------------------------
	localparam logic [5:0] RATIO_1  = 6'h01;
	localparam logic [5:0] RATIO_2  = 6'h02;
	localparam logic [5:0] RATIO_3  = 6'h03;
	localparam logic [5:0] RATIO_4  = 6'h04;
	localparam logic [5:0] RATIO_8  = 6'h08;
	localparam logic [5:0] RATIO_16 = 6'h10;
	localparam logic [5:0] RATIO_32 = 6'h20;

	// ------------------------------------------------------------
	// Reset values of the configuration copies
	// ------------------------------------------------------------
	localparam logic [5:0]  RST_REF_DIV_HI   = 6'h00;
	localparam logic [7:0]  RST_REF_DIV_LO   = 8'h01;
	localparam logic [2:0]  RST_PRESC_MODE   = 3'h0;
	localparam logic [5:0]  RST_SWALLOW      = 6'h00;
	localparam logic [12:0] RST_MAIN         = 13'h0000;
	localparam logic        RST_MAIN_BYPASS  = 1'h0;
	localparam logic        RST_DIST_SEL     = 1'h1;

endpackage

// File: verilog/div_link_if.sv
interface div_link_if;
	import pll_div_pkg::*;

	logic                 en;      // Input edge enable
	logic                 clear;   // Counter restart
	logic [REF_DIV_W-1:0] divisor; // Divide value
	logic                 pulse;   // One-cycle output pulse

	modport ctl (output en, output clear, output divisor, input pulse);
	modport div (input en, input clear, input divisor, output pulse);
endinterface

// File: verilog/edge_divider.sv
module edge_divider
	import pll_div_pkg::*;
(
	input  wire logic sys_clk_i, // System clock
	input  wire logic sys_rst_i, // Synchronous reset, high
	div_link_if.div   link       // Enable, clear, divisor, pulse
);

	logic [REF_DIV_W-1:0] count_reg;
	logic [REF_DIV_W-1:0] last_value;
	logic                 pulse_reg;

	// ------------------------------------------------------------
	// Terminal count
	// ------------------------------------------------------------
	// Zero divisor folds onto one, so the input passes undivided
	always_comb
	begin
		if (link.divisor == '0)
			last_value = '0;
		else
			last_value = link.divisor - REF_DIV_W'(1);
	end

	// Count input edges, wrap at the terminal value
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i || link.clear)
			count_reg <= '0;
		else if (link.en)
		begin
			if (count_reg >= last_value)
				count_reg <= '0;
			else
				count_reg <= count_reg + REF_DIV_W'(1);
		end
	end

	// One pulse per divided period
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i || link.clear)
			pulse_reg <= 1'b0;
		else
			pulse_reg <= link.en && (count_reg >= last_value);
	end

	assign link.pulse = pulse_reg;

endmodule

// File: tb/osc_source.sv
// ------------------------------------------------------------
// Free-running pin source for the reference and oscillator pins
// ------------------------------------------------------------
module osc_source
#(
	parameter int HALF = 2 // Half period in system cycles
)
(
	input  wire logic clk_i, // Bench clock
	input  wire logic en_i,  // Run enable
	output logic      pin_o  // Clock pin
);
	timeunit 1ns;
	timeprecision 100ps;

	int cnt = 0;

	initial pin_o = 1'b0;

	// Rate stays far below every prescaler input limit
	// Stopped source rests low, as a halted oscillator would
	always @(posedge clk_i)
	begin
		if (!en_i)
			pin_o <= 1'b0;
		else if (cnt == HALF - 1)
			pin_o <= !pin_o;
		cnt <= (!en_i || cnt == HALF - 1) ? 0 : cnt + 1;
	end
endmodule

// File: tb/pll_div_asserts.sv
module pll_div_asserts
	import pll_div_pkg::*;
(
	input wire logic              sys_clk_i,                  // Clock
	input wire logic              sys_rst_i,                  // Reset
	input wire logic              oscillator_clock_input_i,   // Oscillator pin
	input wire logic              distribution_clock_input_i, // Distribution pin
	input wire logic [MAIN_W-1:0] main_count_i,               // Main count
	input wire logic              main_count_we_i,            // Main load
	input wire logic              shared_counter_reset_i,     // Shared reset
	input wire logic              feedback_counter_reset_i,   // Feedback reset
	input wire logic              dist_source_sel_i,          // Source select
	input wire logic              pfd_ref_pulse_o,            // Ref pulse
	input wire logic              pfd_fb_pulse_o,             // Fb pulse
	input wire logic              pfd_up_o,                   // Up flag
	input wire logic              pfd_down_o,                 // Down flag
	input wire logic [MAIN_W-1:0] main_count_o,               // Main readback
	input wire logic              dist_clock_o                // Distribution out
);
	timeunit 1ns;
	timeprecision 100ps;

	logic       sel_pin;
	logic [2:0] sel_age_reg;

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	assign sel_pin = dist_source_sel_i ? distribution_clock_input_i : oscillator_clock_input_i;

	// Age of the select; the mux path needs a few cycles to settle after a change
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i || $changed(dist_source_sel_i))
			sel_age_reg <= 3'h0;
		else if (sel_age_reg != 3'h7)
			sel_age_reg <= sel_age_reg + 3'h1;
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	ref_pulse_once_a: assert property (pfd_ref_pulse_o |=> !pfd_ref_pulse_o)
		else $error("ref pulse longer than one cycle");
	fb_pulse_once_a: assert property (pfd_fb_pulse_o |=> !pfd_fb_pulse_o)
		else $error("fb pulse longer than one cycle");
	shared_reset_a: assert property (shared_counter_reset_i [*3] |-> !pfd_ref_pulse_o && !pfd_fb_pulse_o)
		else $error("pulse during shared reset");
	fb_reset_a: assert property (feedback_counter_reset_i [*3] |-> !pfd_fb_pulse_o)
		else $error("fb pulse during feedback reset");
	main_load_a: assert property (main_count_we_i ##1 !main_count_we_i [*2] |-> main_count_o == $past(main_count_i, 2))
		else $error("main count not stored");
	main_hold_a: assert property (!main_count_we_i [*3] |-> $stable(main_count_o))
		else $error("main count changed without load");
	pfd_excl_a: assert property (!(pfd_up_o && pfd_down_o))
		else $error("up and down both set");
	up_set_a: assert property (pfd_ref_pulse_o && !pfd_fb_pulse_o && !pfd_down_o |=> pfd_up_o)
		else $error("up not set after ref pulse");
	down_set_a: assert property (pfd_fb_pulse_o && !pfd_ref_pulse_o && !pfd_up_o |=> pfd_down_o)
		else $error("down not set after fb pulse");
	dist_path_a: assert property (sel_age_reg >= 3'h5 |-> dist_clock_o == $past(sel_pin, 3))
		else $error("distribution output not the selected pin");

	cover property (pfd_ref_pulse_o);
	cover property (pfd_fb_pulse_o);
	cover property ($rose(pfd_up_o));
	cover property ($rose(pfd_down_o));
endmodule

bind pll_ref_and_feedback_dividers pll_div_asserts u_chk (.sys_clk_i, .sys_rst_i,
	.oscillator_clock_input_i, .distribution_clock_input_i, .main_count_i, .main_count_we_i,
	.shared_counter_reset_i, .feedback_counter_reset_i, .dist_source_sel_i, .pfd_ref_pulse_o,
	.pfd_fb_pulse_o, .pfd_up_o, .pfd_down_o, .main_count_o, .dist_clock_o);

// File: tb/tb.sv
module tb
	import pll_div_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int REF_PER = 6; // Reference pin period, cycles
	localparam int OSC_PER = 4; // Oscillator pin period, cycles
	localparam logic [2:0] TM [8] = '{MODE_FD_DIV1, MODE_FD_DIV2, MODE_FD_DIV3, MODE_DM_2_3,
		MODE_DM_4_5, MODE_DM_8_9, MODE_DM_16_17, MODE_DM_32_33};
	localparam int TA [8] = '{5, 0, 9, 2, 1, 2, 0, 1};
	localparam int TB [8] = '{7, 5, 4, 3, 3, 3, 3, 3};
	localparam int TD [8] = '{0, 1, 2, 3, 256, 5, 1, 7};

	logic        sys_clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        reference_clock_input_i;
	logic        oscillator_clock_input_i;
	logic        distribution_clock_input_i = 1'b0;
	logic        main_count_we_i = 1'b0;
	logic        main_bypass_i = 1'b0;
	logic        shared_counter_reset_i = 1'b0;
	logic        feedback_counter_reset_i = 1'b0;
	logic        dist_source_sel_i = 1'b1;
	logic        osc_en = 1'b1;
	logic [5:0]  ref_div_hi_i = 6'h00;
	logic [7:0]  ref_div_lo_i = 8'h01;
	logic [2:0]  prescaler_mode_i = 3'h0;
	logic [5:0]  swallow_count_i = 6'h00;
	logic [12:0] main_count_i = 13'h0000;
	logic [12:0] main_count_o;
	logic        pfd_ref_pulse_o, pfd_fb_pulse_o, pfd_up_o, pfd_down_o, dist_clock_o;
	int          errors = 0;
	int          checked = 0;
	int          cycles = 0;

	osc_source #(.HALF(3)) u_ref (.clk_i(sys_clk_i), .en_i(1'b1), .pin_o(reference_clock_input_i));
	osc_source #(.HALF(2)) u_osc (.clk_i(sys_clk_i), .en_i(osc_en), .pin_o(oscillator_clock_input_i));

	pll_ref_and_feedback_dividers uut (.sys_clk_i, .sys_rst_i, .reference_clock_input_i,
		.oscillator_clock_input_i, .distribution_clock_input_i, .ref_div_hi_i, .ref_div_lo_i,
		.prescaler_mode_i, .swallow_count_i, .main_count_i, .main_count_we_i, .main_bypass_i,
		.shared_counter_reset_i, .feedback_counter_reset_i, .dist_source_sel_i, .pfd_ref_pulse_o,
		.pfd_fb_pulse_o, .pfd_up_o, .pfd_down_o, .main_count_o, .dist_clock_o);

	always #2.5 sys_clk_i = ~sys_clk_i;

	// Noisy distribution pin and the hang guard
	always @(posedge sys_clk_i)
	begin
		distribution_clock_input_i <= 1'($urandom);
		cycles++;
		if (cycles == 40000)
		begin
			errors++;
			conclude();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic conclude;
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Total feedback division from mode, swallow and main count
	function automatic int n_of(logic [2:0] m, int a, int b, bit byp);
		int p;
		int bb;
		bb = byp ? 1 : b;
		case (m)
			MODE_FD_DIV1: return bb;
			MODE_FD_DIV2: return 2 * bb;
			MODE_FD_DIV3: return 3 * bb;
			MODE_DM_2_3: p = 2;
			MODE_DM_4_5: p = 4;
			MODE_DM_8_9: p = 8;
			MODE_DM_16_17: p = 16;
			default: p = 32;
		endcase
		return p * bb + a;
	endfunction

	// Skip to a pulse, then count cycles to the next one
	task automatic meas(input bit fb, input int exp);
		int n;
		n = 0;
		while ((fb ? pfd_fb_pulse_o : pfd_ref_pulse_o) !== 1'b1 && n < 3000)
		begin
			@(posedge sys_clk_i);
			n++;
		end
		n = 0;
		do
		begin
			@(posedge sys_clk_i);
			n++;
		end
		while ((fb ? pfd_fb_pulse_o : pfd_ref_pulse_o) !== 1'b1 && n < 3000);
		check(n, exp);
	endtask

	// Program, restart all counters through both resets, then measure
	task automatic setup(input logic [2:0] m, input int a, input int b, input bit byp, input int d);
		@(posedge sys_clk_i);
		prescaler_mode_i <= m;
		swallow_count_i <= 6'(a);
		main_count_i <= 13'(b);
		main_bypass_i <= byp; // Bypass only with a fixed mode
		{ref_div_hi_i, ref_div_lo_i} <= 14'(d);
		main_count_we_i <= 1'b1;
		shared_counter_reset_i <= 1'b1;
		feedback_counter_reset_i <= 1'b1;
		@(posedge sys_clk_i);
		main_count_we_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		shared_counter_reset_i <= 1'b0;
		// Feedback reset alone holds on, so its own clear path is exercised
		repeat (3) @(posedge sys_clk_i);
		feedback_counter_reset_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		check(main_count_o, 32'(b));
		meas(1'b1, n_of(m, a, b, byp) * OSC_PER);
		meas(1'b1, n_of(m, a, b, byp) * OSC_PER);
		meas(1'b0, (d == 0 ? 1 : d) * REF_PER);
	endtask

	initial
	begin
		int n;
		void'($urandom(32'h3093));
		repeat (4) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		check(main_count_o, 32'h0);
		// Every mode code, bypass in modes 000 and 001, swallow set in modes 000 and 111
		for (int i = 0; i < 8; i++)
			setup(TM[i], TA[i], TB[i], i < 2, TD[i]);
		dist_source_sel_i <= 1'b0;
		// Random settings; main count kept in its valid range
		for (int i = 0; i < 6; i++)
		begin
			n = 3 + int'($urandom % 6);
			setup(3'($urandom), int'($urandom % n), n, 1'b0, int'($urandom % 8));
		end
		// Oscillator halted: the reference pin alone must not clock the feedback path
		osc_en <= 1'b0;
		repeat (20) @(posedge sys_clk_i);
		n = 0;
		repeat (300)
		begin
			@(posedge sys_clk_i);
			if (pfd_fb_pulse_o !== 1'b0)
				n++;
		end
		check(n, 0);
		conclude();
	end
endmodule
